// File: logic/sew_top.sv
// Two-wire serial target with page write and program cycle
`timescale 1ns/1ps
module sew_top #(
  parameter logic [3:0] TYPE_CODE = sew_pkg::TYPE_CODE_DFLT,
  parameter int DEPTH = sew_pkg::BYTES,
  parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES_DFLT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] bus_select_inputs,
  input wire logic wp_i,
  input wire logic [sew_pkg::ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic standby
);
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_SKIP} sew_state_t;

  typedef struct packed {
    sew_state_t state;
    sew_pkg::sew_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [sew_pkg::ADDR_W-1:0] addr;
    logic rw_read;
    logic dirty;
    logic req_tog;
    logic [sew_pkg::ADDR_W-sew_pkg::PAGE_W-1:0] page;
    logic [sew_pkg::PAGE_BYTES-1:0] mask;
    logic [sew_pkg::PAGE_BYTES-1:0][7:0] pbuf;
    logic scl_q;
    logic sda_q;
    logic sda_o;
    logic sda_oe;
    logic standby;
  } sew_link_t;

  sew_link_t st;
  sew_link_t next_st;

  logic rst_sys_n;
  logic rst_link_n;
  logic [5:0] pins;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] sel_s;
  logic ack_seen;
  logic ack_tog;
  logic busy;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic dev_match;
  logic quiet;
  logic byte_end;

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  sew_sync #(.W(1)) u_rst_sys (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(1'b1),
    .q(rst_sys_n)
  );

  sew_sync #(.W(1)) u_rst_link (
    .clk(clk_link),
    .rst_n(rst_n),
    .d(1'b1),
    .q(rst_link_n)
  );

  sew_sync #(.W(6)) u_pins (
    .clk(clk_link),
    .rst_n(rst_link_n),
    .d({scl_i, sda_i, wp_i, bus_select_inputs}),
    .q(pins)
  );

  sew_sync #(.W(1)) u_ack (
    .clk(clk_link),
    .rst_n(rst_link_n),
    .d(ack_tog),
    .q(ack_seen)
  );

  assign scl_s = pins[5];
  assign sda_s = pins[4];
  assign wp_s = pins[3];
  assign sel_s = pins[2:0];

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  assign busy = st.req_tog ^ ack_seen;  // [R17]
  assign scl_rise = scl_s && !st.scl_q;
  assign scl_fall = !scl_s && st.scl_q;
  assign start = scl_s && st.scl_q && st.sda_q && !sda_s;  // [R4]
  assign stop = scl_s && st.scl_q && !st.sda_q && sda_s;  // [R4]
  assign dev_match = (st.shreg[7:sew_pkg::TYPE_LSB] == TYPE_CODE)  // [R10]
    && (st.shreg[sew_pkg::TYPE_LSB-1:sew_pkg::SEL_LSB] == sel_s);  // [R11]

  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;
    next_st.sda_o = 1'b0;  // [R3]
    if (busy) begin
      next_st.state = ST_IDLE;  // [R17] [R21]
      next_st.sda_oe = 1'b0;
    end else if (start) begin
      next_st.state = ST_RX;  // [R5]
      next_st.phase = sew_pkg::PH_DEV;
      next_st.bitcnt = '0;
      next_st.sda_oe = 1'b0;
    end else if (stop) begin
      if (st.dirty && !wp_s) begin
        next_st.req_tog = ~st.req_tog;  // [R16] [R14] [R25]
        next_st.page = st.addr[sew_pkg::ADDR_W-1:sew_pkg::PAGE_W];
      end
      next_st.dirty = 1'b0;
      next_st.state = ST_IDLE;  // [R6]
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.state)
        ST_RX: begin
          if (scl_rise && st.bitcnt < 4'h8) begin
            next_st.shreg = {st.shreg[6:0], sda_s};  // [R2]
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.state = ST_ACK;
            next_st.sda_oe = 1'b1;  // [R7] [R2]
            case (st.phase)
              sew_pkg::PH_DEV: begin
                if (!dev_match) begin
                  next_st.state = ST_IDLE;  // [R13]
                  next_st.sda_oe = 1'b0;
                end else begin
                  next_st.rw_read = st.shreg[sew_pkg::RW_BIT];  // [R12]
                  next_st.phase = sew_pkg::PH_HI;
                end
              end
              sew_pkg::PH_HI: begin
                next_st.addr[sew_pkg::ADDR_W-1:8] = st.shreg[sew_pkg::HI_ADDR_BITS-1:0];  // [R15] [R24]
                next_st.phase = sew_pkg::PH_LO;
              end
              sew_pkg::PH_LO: begin
                next_st.addr[7:0] = st.shreg;  // [R15]
                next_st.mask = '0;
                next_st.phase = sew_pkg::PH_DATA;
              end
              default: begin
                next_st.pbuf[st.addr[sew_pkg::PAGE_W-1:0]] = st.shreg;  // [R18] [R20]
                next_st.mask[st.addr[sew_pkg::PAGE_W-1:0]] = 1'b1;
                next_st.dirty = 1'b1;
                next_st.addr[sew_pkg::PAGE_W-1:0] = st.addr[sew_pkg::PAGE_W-1:0] + 6'h01;  // [R19] [R22]
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe = 1'b0;
            next_st.bitcnt = '0;
            next_st.state = st.rw_read ? ST_SKIP : ST_RX;
          end
        end
        default: begin
        end
      endcase
    end
    next_st.standby = (next_st.state == ST_IDLE) && !busy;  // [R8]
  end

  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sda_o = st.sda_o;
  assign sda_oe = st.sda_oe;
  assign standby = st.standby;

  // ----------------------------------------
  // Array and program cycle
  // ----------------------------------------
  sew_prog #(
    .DEPTH(DEPTH),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog (
    .clk_sys(clk_sys),
    .rst_n(rst_sys_n),
    .req_tog(st.req_tog),
    .page(st.page),
    .mask(st.mask),
    .pbuf(st.pbuf),
    .rd_addr(rd_addr),
    .ack_tog(ack_tog),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  assign quiet = !busy && !start && !stop;
  assign byte_end = quiet && (st.state == ST_RX) && scl_fall && (st.bitcnt == 4'h8);

  a_never_drive_high: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R3]
    !st.sda_o)
    else $error("Data line driven high");

  a_oe_in_ack: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R3]
    st.sda_oe
    |-> (st.state == ST_ACK))
    else $error("Data line pulled outside acknowledge");

  a_ack_after_fall: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R7]
    $rose(st.sda_oe) |-> $past(scl_fall) && ($past(st.bitcnt) == 4'h8))
    else $error("Acknowledge not after eighth falling edge");

  a_ack_stands: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R7]
    (quiet && (st.state == ST_ACK) && !scl_fall)
    |=> st.sda_oe && (st.state == ST_ACK))
    else $error("Acknowledge released early");

  a_ack_release: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R7]
    (quiet && (st.state == ST_ACK) && scl_fall)
    |=> !st.sda_oe && (st.bitcnt == 4'h0))
    else $error("Acknowledge held past ninth clock");

  a_shift_on_rise: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R2]
    (quiet && (st.state == ST_RX) && scl_rise && (st.bitcnt < 4'h8))
    |=> (st.shreg[0] == $past(sda_s)) && (st.bitcnt == $past(st.bitcnt) + 4'h1))
    else $error("Bit not taken on clock rise");

  a_hold_without_edge: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R4]
    (quiet && (st.state == ST_RX) && !scl_rise && !scl_fall)
    |=> $stable(st.shreg) && $stable(st.bitcnt))
    else $error("Bit taken without clock edge");

  a_type_code: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R10]
    (byte_end && (st.phase == sew_pkg::PH_DEV) && (st.shreg[7:sew_pkg::TYPE_LSB] != TYPE_CODE))
    |=> (st.state == ST_IDLE) && !st.sda_oe)
    else $error("Wrong type code acknowledged");

  a_select_pins: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R11]
    (byte_end && (st.phase == sew_pkg::PH_DEV) && (st.shreg[sew_pkg::TYPE_LSB-1:sew_pkg::SEL_LSB] != sel_s))
    |=> (st.state == ST_IDLE) && !st.sda_oe)
    else $error("Wrong select bits acknowledged");

  a_match_acks: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R13]
    (byte_end && (st.phase == sew_pkg::PH_DEV) && dev_match)
    |=> (st.state == ST_ACK) && st.sda_oe && (st.phase == sew_pkg::PH_HI))
    else $error("Matching address not acknowledged");

  a_rw_latched: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R12]
    (byte_end && (st.phase == sew_pkg::PH_DEV) && dev_match)
    |=> (st.rw_read == $past(st.shreg[sew_pkg::RW_BIT])))
    else $error("Operation bit not taken");

  a_read_skips: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R12]
    (quiet && (st.state == ST_ACK) && scl_fall && st.rw_read)
    |=> (st.state == ST_SKIP))
    else $error("Read request took write bytes");

  a_write_receives: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R15]
    (quiet && (st.state == ST_ACK) && scl_fall && !st.rw_read)
    |=> (st.state == ST_RX))
    else $error("Write request stopped receiving");

  a_high_addr: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R24]
    (byte_end && (st.phase == sew_pkg::PH_HI))
    |=> (st.addr[sew_pkg::ADDR_W-1:8] == $past(st.shreg[sew_pkg::HI_ADDR_BITS-1:0])) && (st.phase == sew_pkg::PH_LO))
    else $error("High address byte not taken");

  a_low_addr: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R15]
    (byte_end && (st.phase == sew_pkg::PH_LO))
    |=> (st.addr[7:0] == $past(st.shreg)) && (st.mask == '0) && (st.phase == sew_pkg::PH_DATA))
    else $error("Low address byte not taken");

  a_data_stored: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R18]
    (byte_end && (st.phase == sew_pkg::PH_DATA))
    |=> st.dirty && (st.pbuf[$past(st.addr[sew_pkg::PAGE_W-1:0])] == $past(st.shreg)))
    else $error("Data byte not buffered");

  a_addr_increments: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R22]
    (byte_end && (st.phase == sew_pkg::PH_DATA))
    |=> (st.addr[sew_pkg::PAGE_W-1:0] == $past(st.addr[sew_pkg::PAGE_W-1:0]) + 6'h01))
    else $error("Address counter not advanced");

  a_page_wrap: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R19]
    (byte_end && (st.phase == sew_pkg::PH_DATA))
    |=> $stable(st.addr[sew_pkg::ADDR_W-1:sew_pkg::PAGE_W]))
    else $error("Page bits changed during page write");

  a_commit_on_stop: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R16]
    (stop && !busy && st.dirty && !wp_s)
    |=> (st.req_tog != $past(st.req_tog)) && (st.page == $past(st.addr[sew_pkg::ADDR_W-1:sew_pkg::PAGE_W])))
    else $error("Stop after data did not start program cycle");

  a_clean_stop: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R16]
    (stop && !st.dirty)
    |=> $stable(st.req_tog))
    else $error("Program cycle started without data");

  a_wp_no_commit: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R25]
    (stop && wp_s) |=> $stable(st.req_tog))
    else $error("Program cycle started while protected");

  a_busy_silent: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R17]
    busy |=> !st.sda_oe)
    else $error("Response during program cycle");

  a_busy_idle: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R21]
    busy
    |=> (st.state == ST_IDLE) && !st.standby)
    else $error("Decoding during program cycle");

  a_start_restarts: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R5]
    (start && !busy) |=> (st.state == ST_RX) && (st.bitcnt == 4'h0) && (st.phase == sew_pkg::PH_DEV))
    else $error("Start did not restart decoding");

  a_stop_ends: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R6]
    (stop && !busy) |=> (st.state == ST_IDLE) && !st.sda_oe && !st.dirty)
    else $error("Stop did not end transaction");

  a_mismatch_idle: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R13]
    (!busy && !start && !stop && st.state == ST_RX && st.phase == sew_pkg::PH_DEV
      && scl_fall && st.bitcnt == 4'h8 && !dev_match) |=> (st.state == ST_IDLE) && !st.sda_oe)
    else $error("Mismatched address acknowledged");

  a_idle_standby: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R8]
    (quiet && (st.state == ST_IDLE))
    |=> st.standby)
    else $error("Idle without standby");

  a_standby_state: assert property (@(posedge clk_link) disable iff (!rst_link_n)  // [R8]
    st.standby |-> (st.state == ST_IDLE))
    else $error("Standby outside idle");
endmodule

// File: logic/sew_pkg.sv
// Shared constants of the serial memory write target
// Contract
// [R1] Array is 256 pages of 64 bytes
// [R2] Sample on clock rise, drive after fall
// [R3] Data line only pulled low or released
// [R4] Data change with clock high: start/stop
// [R5] Falling data, clock high: start, restarts decode
// [R6] Rising data, clock high: stop ends transaction
// [R7] Acknowledge low in ninth clock per byte
// [R8] Standby at power-up and after stop
// [R9] Host recovers by clocking nine, then start
// [R10] Address word follows start, type code first
// [R11] Next three bits match select inputs
// [R12] Eighth bit: high read, low write
// [R13] Match acknowledges; mismatch returns to standby
// [R14] Write-protect high blocks all array writes
// [R15] Byte address follows write address word, acknowledged
// [R16] Byte write acknowledged; stop starts program cycle
// [R17] Program cycle ignores bus, no response
// [R18] Page write: up to 63 more bytes
// [R19] Only low six address bits increment
// [R20] Over 64 bytes wrap and overwrite buffer
// [R21] Poll acknowledged only after program completes
// [R22] Address counter keeps last address plus one
// [R23] Program cycle at most 5 ms
// [R24] Byte address two bytes, top bits ignored
// [R25] Protected writes acknowledged but never programmed
package sew_pkg;
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 6;
  localparam int PAGES = 256;
  localparam int PAGE_BYTES = 64;
  localparam int BYTES = PAGES * PAGE_BYTES;
  localparam int BITS_PER_WORD = 8;
  localparam int HI_ADDR_BITS = ADDR_W - BITS_PER_WORD;
  localparam int TYPE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [3:0] TYPE_CODE_DFLT = 4'h6;  // Arbitrary value
  localparam int CLK_MHZ = 125;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {PH_DEV, PH_HI, PH_LO, PH_DATA} sew_phase_t;
endpackage

// File: logic/sew_sync.sv
// Two flip-flop synchroniser
`timescale 1ns/1ps
module sew_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sew_sync_t;

  sew_sync_t st;
  sew_sync_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// File: logic/sew_prog.sv
// Array and self-timed program cycle on the system clock
`timescale 1ns/1ps
module sew_prog #(
  parameter int DEPTH = sew_pkg::BYTES,
  parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES_DFLT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_tog,
  input wire logic [sew_pkg::ADDR_W-sew_pkg::PAGE_W-1:0] page,
  input wire logic [sew_pkg::PAGE_BYTES-1:0] mask,
  input wire logic [sew_pkg::PAGE_BYTES-1:0][7:0] pbuf,
  input wire logic [sew_pkg::ADDR_W-1:0] rd_addr,
  output logic ack_tog,
  output logic [7:0] rd_data
);
  localparam int CW = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    logic req_q;
    logic busy;
    logic [CW-1:0] cnt;
    logic ack_tog;
    logic [7:0] rd_data;
    logic [DEPTH-1:0][7:0] mem;
  } sew_prog_t;

  sew_prog_t st;
  sew_prog_t next_st;
  logic req_s;

  sew_sync #(.W(1)) u_req (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(req_tog),
    .q(req_s)
  );

  // ----------------------------------------
  // Program timer and array update
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.rd_data = st.mem[rd_addr];
    if (req_s != st.req_q) begin
      next_st.req_q = req_s;
      next_st.busy = 1'b1;
      next_st.cnt = '0;
    end else if (st.busy) begin
      if (st.cnt == CW'(PROG_CYCLES - 1)) begin  // [R23]
        for (int i = 0; i < sew_pkg::PAGE_BYTES; i++) begin
          if (mask[i]) begin
            next_st.mem[{page, 6'(i)}] = pbuf[i];  // [R1]
          end
        end
        next_st.busy = 1'b0;
        next_st.ack_tog = ~st.ack_tog;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ack_tog = st.ack_tog;
  assign rd_data = st.rd_data;

  a_prog_duration: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R23]
    $changed(st.ack_tog) |-> ($past(st.cnt) == CW'(PROG_CYCLES - 1)) && $past(st.busy))
    else $error("Program cycle ended at wrong count");
  a_req_starts_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R16]
    (req_s != st.req_q) |=> st.busy && (st.cnt == '0))
    else $error("Commit did not start program cycle");
endmodule

// File: testbench/sew_host.sv
// Two-wire bus controller model for the serial memory
`timescale 1ns/1ps
module sew_host (
  input wire logic clk_link,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_link);
    #1;
  endtask
  // Data changes only with clock low
  task automatic put_bit(input logic b, output logic s);
    wait_n(3);
    sda_low = ~b;
    wait_n(3);
    scl = 1'b1;
    wait_n(6);
    s = sda;
    scl = 1'b0;
  endtask
  // Falling data with clock high
  task automatic start_c();
    sda_low = 1'b0;
    wait_n(6);
    scl = 1'b1;
    wait_n(6);
    sda_low = 1'b1;
    wait_n(6);
    scl = 1'b0;
  endtask
  // Rising data with clock high
  task automatic stop_c();
    sda_low = 1'b1;
    wait_n(6);
    scl = 1'b1;
    wait_n(6);
    sda_low = 1'b0;
    wait_n(6);
  endtask
  // Eight bits MSB first, then the ninth clock samples the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
    end
    put_bit(1'b1, ack);
  endtask
  // Bus recovery: nine clocks with data released
  task automatic recover();
    sda_low = 1'b0;
    repeat (9) begin
      wait_n(6);
      scl = 1'b1;
      wait_n(6);
      scl = 1'b0;
    end
  endtask
endmodule

// File: testbench/test_serial_eeprom_write_target.sv
// Self-checking bench of the serial memory write target
`timescale 1ns/1ps
module test_serial_eeprom_write_target;
  localparam int PROG = 2000;
  localparam logic [3:0] TYPE = 4'h9;  // Arbitrary value
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [7:0] DEV_W = {TYPE, SEL, 1'b0};
  logic clk_sys, clk_link, rst_n, wp_i, scl, sda_low, sda_o, sda_oe, standby, sda;
  logic [13:0] rd_addr;
  logic [7:0] rd_data;
  int failures, cmp_count, cycles;
  // Open-drain wire with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  sew_top #(.TYPE_CODE(TYPE), .PROG_CYCLES(PROG)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .bus_select_inputs(SEL), .wp_i(wp_i),
    .rd_addr(rd_addr), .rd_data(rd_data), .standby(standby));
  sew_host host (.clk_link(clk_link), .sda(sda), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------
  // Clocks and checking
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3;
    forever #16 clk_link = ~clk_link;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic xfer(input logic [7:0] b[$], input logic nack);
    logic a;
    host.start_c();
    foreach (b[i]) begin
      host.wbyte(b[i], a);
      check(a, nack);
    end
    host.stop_c();
  endtask
  task automatic poll(output int n);
    logic a;
    n = 0;
    a = 1'b1;
    while (a !== 1'b0 && n < 40) begin
      host.start_c();
      host.wbyte(DEV_W, a);
      host.stop_c();
      n++;
    end
    check(a, 1'b0);
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    rd_addr = a;
    repeat (2) @(posedge clk_sys);
    #1;
    check(rd_data, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_byte_write();
    int n;
    check(standby, 1'b1);
    xfer('{DEV_W, 8'h01, 8'h05, 8'hA5}, 1'b0);
    host.wait_n(10);
    check(standby, 1'b0);
    poll(n);
    check(n > 1, 1'b1);
    check(standby, 1'b1);
    rd(14'h0105, 8'hA5);
  endtask
  task automatic t_select();
    logic a;
    host.start_c();
    host.wbyte({TYPE, SEL ^ 3'h3, 1'b0}, a);
    check(a, 1'b1);
    host.wait_n(10);
    check(standby, 1'b1);
    host.stop_c();
    xfer('{{4'h3, SEL, 1'b0}}, 1'b1);
    xfer('{DEV_W | 8'h01}, 1'b0);
  endtask
  task automatic t_page();
    logic [7:0] b[$];
    int n;
    b = '{DEV_W, 8'hC0, 8'hBE};
    for (int i = 0; i < 66; i++) begin
      b.push_back(8'h10 + i[7:0]);
    end
    xfer(b, 1'b0);
    poll(n);
    rd(14'h00BE, 8'h50);
    rd(14'h00BF, 8'h51);
    rd(14'h0080, 8'h12);
    rd(14'h00BD, 8'h4F);
  endtask
  task automatic t_protect();
    wp_i = 1'b1;
    xfer('{DEV_W, 8'h01, 8'h05, 8'h3C}, 1'b0);
    host.wait_n(10);
    check(standby, 1'b1);
    wp_i = 1'b0;
    rd(14'h0105, 8'hA5);
  endtask
  task automatic t_restart();
    logic a;
    int n;
    host.start_c();
    host.wbyte(DEV_W, a);
    host.wbyte(8'h03, a);
    xfer('{DEV_W, 8'h02, 8'h00, 8'h77}, 1'b0);
    poll(n);
    rd(14'h0200, 8'h77);
    check(sda_o, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    wp_i = 1'b0;
    rd_addr = '0;
    repeat (2) @(posedge clk_link);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    host.wait_n(10);
    host.recover();
    t_byte_write();
    t_select();
    t_page();
    t_protect();
    t_restart();
    tally_and_finish();
  end
endmodule
